// [rtl/fsb_data_phase.sv]
// Data-phase end of the processor bus: quad-pumped 64-bit send/receive.
// Assumes link_clk runs at the beat rate, four beats per bus clock,
// and both agents leave reset together so beat phases line up.
`timescale 1ns/1ps
module fsb_data_phase
  import fsb_data_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  input  wire logic                  link_clk,
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  input  wire logic [LINE_W-1:0]     tx_line,
  input  wire logic                  tx_last,
  output logic                       rx_valid,
  input  wire logic                  rx_ready,
  output logic [LINE_W-1:0]          rx_line,
  output logic                       rx_overrun,
  output logic                       txn_deferred,
  output logic [1:0]                 bus_freq_select,
  input  wire logic [DATA_W-1:0]     bus_data_n_in,
  output logic [DATA_W-1:0]          bus_data_n_out,
  output logic                       bus_data_oe,
  input  wire logic [NUM_GROUPS-1:0] data_strobe_pos_n_in,
  output logic [NUM_GROUPS-1:0]      data_strobe_pos_n_out,
  input  wire logic [NUM_GROUPS-1:0] data_strobe_neg_n_in,
  output logic [NUM_GROUPS-1:0]      data_strobe_neg_n_out,
  output logic                       strobe_oe,
  input  wire logic                  data_valid_n_in,
  output logic                       data_valid_n_out,
  output logic                       data_valid_oe,
  input  wire logic                  data_bus_occupied_n_in,
  output logic                       data_bus_occupied_n_out,
  output logic                       occupied_oe,
  input  wire logic                  out_of_order_hint_n
);

  logic                  link_rst_meta;
  logic                  link_rst_n;
  logic                  ce_meta;
  logic                  link_ce;
  logic [PIN_IN_W-1:0]   in_meta;
  logic [PIN_IN_W-1:0]   in_sync;
  logic [DATA_W-1:0]     data_n_sync;
  logic [NUM_GROUPS-1:0] pos_sync;
  logic [NUM_GROUPS-1:0] neg_sync;
  logic [NUM_GROUPS-1:0] pos_prev;
  logic [NUM_GROUPS-1:0] neg_prev;
  logic                  valid_n_sync;
  logic                  peer_free;
  logic [1:0]            phase;
  logic [1:0]            next_phase;
  tx_state_t             state;
  tx_state_t             next_state;
  logic                  load;
  logic [LINE_W-1:0]     hold_line;
  logic                  hold_last;
  logic [LINE_W-1:0]     next_line;
  logic                  txf_valid;
  logic [LINE_W:0]       txf_data;
  logic                  rxf_ready;
  logic [NUM_GROUPS-1:0] all_done;
  logic [LINE_W-1:0]     rx_asm;
  logic                  line_push;
  logic                  overrun_link;
  logic                  ovr_meta;
  logic                  ovr_sync;
  logic                  hint_meta;
  logic                  hint_sync;
  logic [2:0]            drive_hist;

  // Link-side reset and enable, released in the link domain
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_rst_meta <= 1'h0;
      link_rst_n    <= 1'h0;
      ce_meta       <= 1'h0;
      link_ce       <= 1'h0;
    end
    else
    begin
      link_rst_meta <= 1'h1;
      link_rst_n    <= link_rst_meta;
      ce_meta       <= clk_en;
      link_ce       <= ce_meta;
    end
  end

  // Core domain: select pattern, hint and overrun crossings
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_freq_select <= BUS_FREQ_SEL_133;
      hint_meta       <= PIN_IDLE;
      hint_sync       <= PIN_IDLE;
      txn_deferred    <= 1'h0;
      ovr_meta        <= 1'h0;
      ovr_sync        <= 1'h0;
      rx_overrun      <= 1'h0;
    end
    else if (clk_en)
    begin
      bus_freq_select <= BUS_FREQ_SEL_133;
      hint_meta       <= out_of_order_hint_n;
      hint_sync       <= hint_meta;
      txn_deferred    <= ~hint_sync;
      ovr_meta        <= overrun_link;
      ovr_sync        <= ovr_meta;
      rx_overrun      <= ovr_sync;
    end
  end

  // Pins pass two flops; strobes get a third stage for edge detection
  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      in_meta  <= '1;
      in_sync  <= '1;
      pos_prev <= '1;
      neg_prev <= '1;
      drive_hist <= 3'h0;
    end
    else if (link_ce)
    begin
      in_meta  <= {bus_data_n_in, data_strobe_pos_n_in,
                   data_strobe_neg_n_in, data_valid_n_in,
                   data_bus_occupied_n_in};
      in_sync  <= in_meta;
      pos_prev <= pos_sync;
      neg_prev <= neg_sync;
      // Own beats linger in the sync stages after the drive stops
      drive_hist <= {drive_hist[1:0], bus_data_oe};
    end
  end

  assign data_n_sync  = in_sync[PIN_IN_W-1 -: DATA_W];
  assign pos_sync     = in_sync[2 + 2 * NUM_GROUPS - 1 -: NUM_GROUPS];
  assign neg_sync     = in_sync[2 + NUM_GROUPS - 1 -: NUM_GROUPS];
  assign valid_n_sync = in_sync[1];
  // bus counts free only once released
  assign peer_free    = in_sync[0];

  // four beat phases per common bus clock
  assign next_phase = phase + 2'h1;

  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      phase <= PHASE_FIRST;
    else if (link_ce)
      phase <= next_phase;
  end

  // Lines are taken only on a bus clock boundary
  always_comb
  begin
    next_state = state;
    load       = 1'h0;
    if (phase == PHASE_LAST)
    begin
      case (state)
        ST_IDLE:
        begin
          // wait until the peer is off the bus
          if (txf_valid && peer_free)
          begin
            next_state = ST_DRIVE;
            load       = 1'h1;
          end
        end
        ST_DRIVE:
        begin
          if (hold_last)
            next_state = ST_IDLE;
          else if (txf_valid)
            load = 1'h1;
          else
            next_state = ST_GAP;
        end
        ST_GAP:
        begin
          if (txf_valid)
          begin
            next_state = ST_DRIVE;
            load       = 1'h1;
          end
        end
        default:
          next_state = ST_IDLE;
      endcase
    end
  end

  assign next_line = load ? txf_data[LINE_W-1:0] : hold_line;

  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state     <= ST_IDLE;
      hold_line <= '0;
      hold_last <= 1'h0;
    end
    else if (link_ce)
    begin
      state <= next_state;
      if (load)
      begin
        hold_line <= txf_data[LINE_W-1:0];
        hold_last <= txf_data[LINE_W];
      end
    end
  end

  // Pins are registered from the next state and beat
  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bus_data_n_out          <= '1;
      bus_data_oe             <= 1'h0;
      data_strobe_pos_n_out   <= '1;
      data_strobe_neg_n_out   <= '1;
      strobe_oe               <= 1'h0;
      data_valid_n_out        <= PIN_IDLE;
      data_valid_oe           <= 1'h0;
      data_bus_occupied_n_out <= PIN_IDLE;
      occupied_oe             <= 1'h0;
    end
    else if (link_ce)
    begin
      data_bus_occupied_n_out <= next_state == ST_IDLE;
      occupied_oe             <= next_state != ST_IDLE;
      data_valid_n_out        <= next_state != ST_DRIVE;
      data_valid_oe           <= next_state != ST_IDLE;
      bus_data_oe             <= next_state == ST_DRIVE;
      strobe_oe               <= next_state == ST_DRIVE;
      // one 64-bit beat per link cycle
      bus_data_n_out <= ~next_line[int'(next_phase) * DATA_W +: DATA_W];
      // positive falls on even beats, negative on odd
      if (next_state == ST_DRIVE)
      begin
        data_strobe_pos_n_out <= {NUM_GROUPS{next_phase[0]}};
        data_strobe_neg_n_out <= {NUM_GROUPS{~next_phase[0]}};
      end
      else
      begin
        data_strobe_pos_n_out <= '1;
        data_strobe_neg_n_out <= '1;
      end
    end
  end

  // each 16-bit group captured on its own strobe pair
  for (genvar g = 0; g < NUM_GROUPS; g++)
  begin : g_grp
    logic                       fall;
    logic [1:0]                 beat;
    logic                       done;
    logic [BEATS*GROUP_W-1:0]   grp_buf;

    assign fall = (pos_prev[g] & ~pos_sync[g])
                | (neg_prev[g] & ~neg_sync[g]);
    assign all_done[g] = done;

    always_ff @(posedge link_clk or negedge link_rst_n)
    begin
      if (!link_rst_n)
      begin
        beat    <= PHASE_FIRST;
        done    <= 1'h0;
        grp_buf <= '0;
      end
      else if (link_ce)
      begin
        if (fall && !valid_n_sync && !bus_data_oe && drive_hist == 3'h0)
        begin
          grp_buf[int'(beat) * GROUP_W +: GROUP_W] <=
            ~data_n_sync[g * GROUP_W +: GROUP_W];
          beat <= beat + 2'h1;
          // Next line may start in the push cycle
          if (beat == PHASE_LAST)
            done <= 1'h1;
          else if (line_push)
            done <= 1'h0;
        end
        else if (line_push)
          done <= 1'h0;
      end
    end

    for (genvar b = 0; b < BEATS; b++)
    begin : g_beat
      assign rx_asm[b * DATA_W + g * GROUP_W +: GROUP_W] =
        grp_buf[b * GROUP_W +: GROUP_W];
    end
  end

  assign line_push = &all_done;

  // The far agent cannot be stalled, so a full buffer drops the line
  always_ff @(posedge link_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      overrun_link <= 1'h0;
    else if (link_ce && line_push && !rxf_ready)
      overrun_link <= 1'h1;
  end

  async_pair_fifo #(.W(LINE_W + 1)) u_tx_fifo
  (
    .wr_clk   (core_clk),
    .wr_rst_n (reset_n),
    .wr_ce    (clk_en),
    .wr_valid (tx_valid),
    .wr_ready (tx_ready),
    .wr_data  ({tx_last, tx_line}),
    .rd_clk   (link_clk),
    .rd_rst_n (link_rst_n),
    .rd_ce    (link_ce),
    .rd_valid (txf_valid),
    .rd_ready (load),
    .rd_data  (txf_data)
  );

  async_pair_fifo #(.W(LINE_W)) u_rx_fifo
  (
    .wr_clk   (link_clk),
    .wr_rst_n (link_rst_n),
    .wr_ce    (link_ce),
    .wr_valid (line_push),
    .wr_ready (rxf_ready),
    .wr_data  (rx_asm),
    .rd_clk   (core_clk),
    .rd_rst_n (reset_n),
    .rd_ce    (clk_en),
    .rd_valid (rx_valid),
    .rd_ready (rx_ready),
    .rd_data  (rx_line)
  );

  sequence s_beats_on;
    !data_valid_n_out [*4];
  endsequence

  sequence s_beats_off;
    (data_valid_n_out && !data_bus_occupied_n_out) [*4];
  endsequence

  property p_bus_sel;
    @(posedge core_clk) disable iff (!reset_n)
    clk_en |=> bus_freq_select == BUS_FREQ_SEL_133;
  endproperty
  a_bus_sel: assert property (p_bus_sel)
    else $error("bus select not at 133 MHz pattern");

  property p_common_clock;
    @(posedge link_clk) disable iff (!link_rst_n)
    phase == PHASE_LAST && link_ce |=> phase == PHASE_FIRST;
  endproperty
  a_common_clock: assert property (p_common_clock)
    else $error("beat phase did not wrap after four beats");

  property p_valid_drives;
    @(posedge link_clk) disable iff (!link_rst_n)
    !data_valid_n_out |-> bus_data_oe && data_valid_oe;
  endproperty
  a_valid_drives: assert property (p_valid_drives)
    else $error("data valid without driving data");

  property p_quad_pump;
    @(posedge link_clk) disable iff (!link_rst_n)
    $fell(data_valid_n_out) |-> s_beats_on;
  endproperty
  a_quad_pump: assert property (p_quad_pump)
    else $error("fewer than four beats in a bus clock");

  property p_strobe_alt;
    @(posedge link_clk) disable iff (!link_rst_n)
    strobe_oe ##1 strobe_oe && link_ce |->
      data_strobe_pos_n_out == ~$past(data_strobe_pos_n_out)
      && data_strobe_neg_n_out == ~data_strobe_pos_n_out;
  endproperty
  a_strobe_alt: assert property (p_strobe_alt)
    else $error("strobe pair not alternating");

  property p_group_strobes;
    @(posedge link_clk) disable iff (!link_rst_n)
    strobe_oe |-> data_strobe_pos_n_out == '0
      || data_strobe_pos_n_out == '1;
  endproperty
  a_group_strobes: assert property (p_group_strobes)
    else $error("group strobes out of step");

  property p_busy_owner;
    @(posedge link_clk) disable iff (!link_rst_n)
    bus_data_oe |-> !data_bus_occupied_n_out && occupied_oe;
  endproperty
  a_busy_owner: assert property (p_busy_owner)
    else $error("data driven without bus occupied");

  property p_release;
    @(posedge link_clk) disable iff (!link_rst_n)
    $rose(data_bus_occupied_n_out) |-> !bus_data_oe && data_valid_n_out;
  endproperty
  a_release: assert property (p_release)
    else $error("data still driven after release");

  property p_idle_clock;
    @(posedge link_clk) disable iff (!link_rst_n)
    $rose(data_valid_n_out) && !data_bus_occupied_n_out
      |-> s_beats_off ##1 !data_bus_occupied_n_out;
  endproperty
  a_idle_clock: assert property (p_idle_clock)
    else $error("bus let go during idle clock");

  property p_wait_free;
    @(posedge link_clk) disable iff (!link_rst_n)
    $fell(data_bus_occupied_n_out) |-> $past(peer_free);
  endproperty
  a_wait_free: assert property (p_wait_free)
    else $error("bus taken while peer held it");

endmodule

// [include/fsb_data_pkg.sv]
// Constants and types shared by the data-phase link logic.
// Assumes the link clock runs at the beat rate, four beats per bus clock.
package fsb_data_pkg;

  localparam int DATA_W     = 64;
  localparam int GROUP_W    = 16;
  localparam int NUM_GROUPS = 4;
  localparam int BEATS      = 4;
  localparam int LINE_W     = DATA_W * BEATS;
  localparam int PIN_IN_W   = DATA_W + 2 * NUM_GROUPS + 2;

  // Bus clock and transfer rate in MHz
  localparam int BCLK_MHZ = 133;
  localparam int XFER_MHZ = 533;

  // Select pattern for the 133 MHz bus clock; value after reset too
  localparam logic [1:0] BUS_FREQ_SEL_133 = 2'h1;

  // Beat phases within one bus clock
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_LAST  = 2'h3;

  // Two-entry crossing buffer
  localparam int FIFO_DEPTH = 2;
  localparam int PTR_W      = 2;

  // Deasserted level of a low-active pin
  localparam logic PIN_IDLE = 1'h1;

  typedef enum {ST_IDLE, ST_DRIVE, ST_GAP} tx_state_t;

endpackage

// [rtl/async_pair_fifo.sv]
// Two-entry buffer between two clock domains, gray-coded pointers.
// Assumes each side has its own reset, released in its own domain.
`timescale 1ns/1ps
module async_pair_fifo
  import fsb_data_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         wr_clk,
  input  wire logic         wr_rst_n,
  input  wire logic         wr_ce,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_clk,
  input  wire logic         rd_rst_n,
  input  wire logic         rd_ce,
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data
);

  logic [W-1:0]     mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_bin;
  logic [PTR_W-1:0] wr_gray;
  logic [PTR_W-1:0] next_wr_bin;
  logic [PTR_W-1:0] rd_bin;
  logic [PTR_W-1:0] rd_gray;
  logic [PTR_W-1:0] next_rd_bin;
  logic [PTR_W-1:0] rd_gray_meta;
  logic [PTR_W-1:0] rd_gray_sync;
  logic [PTR_W-1:0] wr_gray_meta;
  logic [PTR_W-1:0] wr_gray_sync;
  logic             wr_fire;
  logic             rd_fire;

  function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  assign wr_fire     = wr_ce & wr_valid & wr_ready;
  assign rd_fire     = rd_ce & rd_valid & rd_ready;
  assign next_wr_bin = wr_bin + PTR_W'(wr_fire);
  assign next_rd_bin = rd_bin + PTR_W'(rd_fire);

  always_ff @(posedge wr_clk)
  begin
    if (wr_fire)
      mem[wr_bin[0]] <= wr_data;
  end

  // Ready is registered; a stale read pointer only makes it pessimistic
  always_ff @(posedge wr_clk or negedge wr_rst_n)
  begin
    if (!wr_rst_n)
    begin
      wr_bin       <= '0;
      wr_gray      <= '0;
      wr_ready     <= 1'h0;
      rd_gray_meta <= '0;
      rd_gray_sync <= '0;
    end
    else
    begin
      rd_gray_meta <= rd_gray;
      rd_gray_sync <= rd_gray_meta;
      if (wr_ce)
      begin
        wr_bin   <= next_wr_bin;
        wr_gray  <= to_gray(next_wr_bin);
        wr_ready <= to_gray(next_wr_bin) != ~rd_gray_sync;
      end
    end
  end

  // Data register loads with valid, after the entry has settled
  always_ff @(posedge rd_clk or negedge rd_rst_n)
  begin
    if (!rd_rst_n)
    begin
      rd_bin       <= '0;
      rd_gray      <= '0;
      rd_valid     <= 1'h0;
      rd_data      <= '0;
      wr_gray_meta <= '0;
      wr_gray_sync <= '0;
    end
    else
    begin
      wr_gray_meta <= wr_gray;
      wr_gray_sync <= wr_gray_meta;
      if (rd_ce)
      begin
        rd_bin   <= next_rd_bin;
        rd_gray  <= to_gray(next_rd_bin);
        rd_valid <= to_gray(next_rd_bin) != wr_gray_sync;
        rd_data  <= mem[next_rd_bin[0]];
      end
    end
  end

endmodule

// [test/far_agent_model.sv]
// Far bus agent: sends lines on strobe pairs, captures device lines.
// Assumes the bench resolves every pin from both enables, pulled high.
`timescale 1ns/1ps
module far_agent_model
  import fsb_data_pkg::*;
(
  input  wire logic                  link_clk,
  input  wire logic [DATA_W-1:0]     dev_data_n,
  input  wire logic                  dev_data_oe,
  input  wire logic [NUM_GROUPS-1:0] dev_pos_n,
  input  wire logic [NUM_GROUPS-1:0] dev_neg_n,
  input  wire logic                  dev_valid_n,
  input  wire logic                  occupied_n,
  output logic [DATA_W-1:0]          far_data_n,
  output logic [NUM_GROUPS-1:0]      far_pos_n,
  output logic [NUM_GROUPS-1:0]      far_neg_n,
  output logic                       far_valid_n,
  output logic                       far_oe,
  output logic                       far_occ_n,
  output logic                       far_occ_oe,
  output logic                       strobe_bad
);
  logic [LINE_W-1:0] got_q[$];
  logic [LINE_W-1:0] acc;
  int                beat;

  initial
  begin
    far_data_n  = '1;
    far_pos_n   = '1;
    far_neg_n   = '1;
    far_valid_n = 1'h1;
    far_oe      = 1'h0;
    far_occ_n   = 1'h1;
    far_occ_oe  = 1'h0;
    strobe_bad  = 1'h0;
    beat        = 0;
  end

  // beats taken while valid, strobes per beat
  always @(posedge link_clk)
  begin
    if (dev_data_oe && !dev_valid_n)
    begin
      acc[beat*DATA_W +: DATA_W] = ~dev_data_n;
      if (dev_pos_n !== {NUM_GROUPS{beat[0]}} || dev_neg_n !== ~dev_pos_n)
        strobe_bad = 1'h1;
      beat = (beat + 1) % BEATS;
      if (beat == 0)
        got_q.push_back(acc);
    end
  end

  task automatic hold_bus(input logic on);
    @(posedge link_clk);
    #1;
    far_occ_n  = !on;
    far_occ_oe = on;
  endtask

  task automatic send_line(input logic [LINE_W-1:0] line);
    int i;
    @(posedge link_clk);
    // never start over a busy bus
    while (!occupied_n)
      @(posedge link_clk);
    #1;
    // occupied for the whole line only
    far_occ_n  = 1'h0;
    far_occ_oe = 1'h1;
    for (i = 0; i < BEATS; i++)
    begin
      far_oe      = 1'h1;
      far_valid_n = 1'h0;
      far_data_n  = ~line[i*DATA_W +: DATA_W];
      far_pos_n   = {NUM_GROUPS{i[0]}};
      far_neg_n   = ~far_pos_n;
      @(posedge link_clk);
      #1;
    end
    far_oe      = 1'h0;
    far_valid_n = 1'h1;
    far_occ_n   = 1'h1;
    far_occ_oe  = 1'h0;
  endtask
endmodule

// [test/fsb_data_phase_tb.sv]
// Self-checking bench for the data-phase link block.
// Assumes pins pulled high when no agent drives them.
`timescale 1ns/1ps
module fsb_data_phase_tb
  import fsb_data_pkg::*;
;
  logic core_clk, reset_n, clk_en, link_clk, tx_valid, tx_ready, tx_last;
  logic rx_valid, rx_ready, rx_overrun, txn_deferred, hint_n;
  logic [LINE_W-1:0]     tx_line, rx_line;
  logic [1:0]            freq_sel;
  logic [DATA_W-1:0]     d_data, f_data, w_data;
  logic [NUM_GROUPS-1:0] d_pos, d_neg, f_pos, f_neg, w_pos, w_neg;
  logic d_valid, d_valid_oe, f_valid, w_valid, data_oe, strobe_oe, f_oe;
  logic d_occ, occ_oe, f_occ, f_occ_oe, w_occ, strobe_bad;
  int   err_total = 0;
  int   total_checks = 0;
  int   cycles = 0;

  assign w_data  = data_oe ? d_data : (f_oe ? f_data : '1);
  assign w_pos   = strobe_oe ? d_pos : (f_oe ? f_pos : '1);
  assign w_neg   = strobe_oe ? d_neg : (f_oe ? f_neg : '1);
  assign w_valid = d_valid_oe ? d_valid : (f_oe ? f_valid : 1'h1);
  assign w_occ   = (occ_oe ? d_occ : 1'h1) & (f_occ_oe ? f_occ : 1'h1);

  fsb_data_phase dut_u (.core_clk(core_clk), .reset_n(reset_n),
    .clk_en(clk_en), .link_clk(link_clk), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_line(tx_line), .tx_last(tx_last),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_line(rx_line),
    .rx_overrun(rx_overrun), .txn_deferred(txn_deferred),
    .bus_freq_select(freq_sel), .bus_data_n_in(w_data),
    .bus_data_n_out(d_data), .bus_data_oe(data_oe),
    .data_strobe_pos_n_in(w_pos), .data_strobe_pos_n_out(d_pos),
    .data_strobe_neg_n_in(w_neg), .data_strobe_neg_n_out(d_neg),
    .strobe_oe(strobe_oe), .data_valid_n_in(w_valid),
    .data_valid_n_out(d_valid), .data_valid_oe(d_valid_oe),
    .data_bus_occupied_n_in(w_occ), .data_bus_occupied_n_out(d_occ),
    .occupied_oe(occ_oe), .out_of_order_hint_n(hint_n));

  far_agent_model part_u (.link_clk(link_clk), .dev_data_n(w_data),
    .dev_data_oe(data_oe), .dev_pos_n(w_pos), .dev_neg_n(w_neg),
    .dev_valid_n(w_valid), .occupied_n(w_occ), .far_data_n(f_data),
    .far_pos_n(f_pos), .far_neg_n(f_neg), .far_valid_n(f_valid),
    .far_oe(f_oe), .far_occ_n(f_occ), .far_occ_oe(f_occ_oe),
    .strobe_bad(strobe_bad));

  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Unrelated phase to the core clock
  initial
  begin
    link_clk = 1'h0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  // Cut a hang short
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [LINE_W-1:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [LINE_W-1:0] mk(input logic [7:0] s);
    for (int b = 0; b < LINE_W / 8; b++)
      mk[b*8 +: 8] = s ^ 8'(b * 37);
  endfunction

  task automatic push(input logic [LINE_W-1:0] line, input logic last);
    int   n;
    logic ok;
    if (!tx_valid)
      tx_valid = 1'h1;
    tx_line = line;
    tx_last = last;
    for (n = 0; n < 200; n++)
    begin
      ok = tx_ready;
      tick(1);
      if (ok === 1'h1)
        break;
    end
    check(ok, 1'h1);
    if (last)
      tx_valid = 1'h0;
  endtask

  task automatic pop_check(input logic [LINE_W-1:0] exp);
    int                n;
    logic              ok;
    logic [LINE_W-1:0] got;
    rx_ready = 1'h1;
    for (n = 0; n < 200; n++)
    begin
      ok  = rx_valid;
      got = rx_line;
      tick(1);
      if (ok === 1'h1)
        break;
    end
    rx_ready = 1'h0;
    check(got, exp);
  endtask

  task automatic got_check(input logic [LINE_W-1:0] exp);
    int n;
    for (n = 0; n < 300 && part_u.got_q.size() == 0; n++)
      tick(1);
    if (part_u.got_q.size() == 0)
      check('0, exp);
    else
      check(part_u.got_q.pop_front(), exp);
  endtask

  task automatic t_reset();
    check(freq_sel, BUS_FREQ_SEL_133);
    check({occ_oe, data_oe, rx_overrun}, '0);
  endtask

  task automatic t_tx_pair();
    push(mk(8'h11), 1'h0);
    push(mk(8'h5C), 1'h0);
    tx_valid = 1'h0;
    got_check(mk(8'h11));
    got_check(mk(8'h5C));
    check({occ_oe, w_occ}, 2'h2);
    push(mk(8'h2B), 1'h1);
    got_check(mk(8'h2B));
    check(strobe_bad, 1'h0);
    tick(60);
    check({occ_oe, w_occ}, 2'h1);
  endtask

  task automatic t_blocked();
    int n;
    part_u.hold_bus(1'h1);
    tick(1);
    push(mk(8'hA7), 1'h1);
    for (n = 0; n < 40; n++)
    begin
      tick(1);
      check(data_oe, 1'h0);
    end
    part_u.hold_bus(1'h0);
    tick(1);
    got_check(mk(8'hA7));
  endtask

  task automatic t_rx_overrun();
    part_u.send_line(mk(8'h3E));
    part_u.send_line(mk(8'hC1));
    part_u.send_line(mk(8'h96));
    tick(40);
    check(rx_overrun, 1'h1);
    pop_check(mk(8'h3E));
    tick(1);
    pop_check(mk(8'hC1));
    tick(20);
    check(rx_valid, 1'h0);
  endtask

  task automatic t_out_of_order_hint_n();
    clk_en = 1'h0;
    hint_n = 1'h0;
    tick(6);
    check(txn_deferred, 1'h0);
    clk_en = 1'h1;
    tick(2);
    check(txn_deferred, 1'h0);
    tick(2);
    check(txn_deferred, 1'h1);
    hint_n = 1'h1;
    tick(4);
    check(txn_deferred, 1'h0);
  endtask

  initial
  begin
    reset_n  = 1'h0;
    clk_en   = 1'h1;
    tx_valid = 1'h0;
    tx_last  = 1'h0;
    tx_line  = '0;
    rx_ready = 1'h0;
    hint_n   = 1'h1;
    // Link side needs several of its own edges in reset
    repeat (10) @(posedge link_clk);
    tick(1);
    reset_n = 1'h1;
    repeat (8) @(posedge link_clk);
    tick(1);
    t_reset();
    t_tx_pair();
    t_blocked();
    t_rx_overrun();
    t_out_of_order_hint_n();
    tally_and_finish();
  end
endmodule
